// [rtl/clg_pkg.sv]
// Functional notes
// - Up to four independent gates; the number in use is configurable, at most four.
// - Each gate uses 1 to 4 inputs; unused positions are left out of the result.
// - Each gate combines its inputs by AND, OR, XOR or AND with feedback.
// - Each input may be taken true or complemented before combining.
// - Output objects are bit or byte wide, and their count is selectable.
// - A bit switching output may be complemented, so a one sends off.
// - Each input comes from its own bus object or a chosen internal bit.
// - A gate is evaluated only when a new input value arrives for it.
// - With AND with feedback the gate result, before its on and off delays, is fed back into input one.
// - Feedback AND goes to one only when input one gets a one, others one.
// - When another input drops to zero, output and held input one clear.
// - An output may feed its own gate, directly or via others, harmlessly.
// - Outputs have a configurable on delay and off delay before applying.
// - While the on delay runs, each further one restarts it.
// - Each repeated zero at the output restarts the off delay.
// - An output state is sent only after its delay fully expires.
// - Sending is triggered by input event, output change, or cyclic only.
// - Optional cyclic resend of the output objects at a configured interval.
// - Separate sent values for zero and one: a command bit or a byte.
package clg_pkg;

  localparam int unsigned NUM_GATES   = 4;
  localparam int unsigned NUM_INPUTS  = 4;

  // Timing: delays and cyclic periods count in milliseconds
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG0   = 8'h10;
  localparam logic [7:0] REG_SRC0   = 8'h20;
  localparam logic [7:0] REG_VAL0   = 8'h30;
  localparam logic [7:0] REG_DLY0   = 8'h40;
  localparam logic [7:0] REG_CYC0   = 8'h50;

  // CTRL fields
  localparam int unsigned CTRL_GCNT_LSB = 0;
  localparam logic [2:0]  GCNT_RST      = 3'h4;

  // CFG fields
  localparam int unsigned CFG_OP_LSB    = 0;
  localparam int unsigned CFG_NIN_LSB   = 2;
  localparam int unsigned CFG_INV_LSB   = 4;
  localparam int unsigned CFG_BYTE_BIT  = 8;
  localparam int unsigned CFG_TWO_BIT   = 9;
  localparam int unsigned CFG_OINV_BIT  = 10;
  localparam int unsigned CFG_MODE_LSB  = 11;
  localparam int unsigned CFG_CYCEN_BIT = 13;
  localparam logic [13:0] CFG_RST       = 14'h0000;

  // VAL fields
  localparam int unsigned VAL_B0_LSB   = 0;
  localparam int unsigned VAL_B1_LSB   = 8;
  localparam int unsigned VAL_CMD0_BIT = 16;
  localparam int unsigned VAL_CMD1_BIT = 17;
  localparam logic [17:0] VAL_RST      = 18'h20000;

  // Input source encoding
  localparam logic [3:0] SRC_EXT      = 4'h0;
  localparam logic [3:0] SRC_INT_BASE = 4'h1;
  localparam logic [3:0] SRC_INT_LAST = 4'h8;
  localparam logic [3:0] SRC_GATE_BASE = 4'h9;
  localparam logic [3:0] SRC_GATE_LAST = 4'hC;

  typedef enum logic [1:0] {
    CLG_OP_AND,
    CLG_OP_OR,
    CLG_OP_XOR,
    CLG_OP_AND_FB
  } clg_op_t;

  typedef enum logic [1:0] {
    CLG_SEND_EVENT,
    CLG_SEND_CHANGE,
    CLG_SEND_CYCLIC,
    CLG_SEND_RSVD
  } clg_send_t;

endpackage

// [rtl/clg_gates.sv]
`timescale 1ns/1ps
module clg_gates #(
  parameter int unsigned TICK_CYCLES = clg_pkg::TICK_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Incoming value for an external input object
  input  wire logic        obj_valid_in,
  input  wire logic [1:0]  obj_gate_in,
  input  wire logic [1:0]  obj_input_in,
  input  wire logic        obj_value_in,
  // Internal 1-bit sources (limits, dew point alarm)
  input  wire logic [7:0]  int_bits_in,
  // Outgoing output object telegrams
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic      [1:0]  tx_gate_out,
  output logic             tx_obj_out,
  output logic             tx_byte_out,
  output logic      [7:0]  tx_data_out
);

  localparam int unsigned NG = clg_pkg::NUM_GATES;
  localparam int unsigned NI = clg_pkg::NUM_INPUTS;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  function automatic logic src_val(input logic [3:0] sel, input logic [11:0] bits);
    logic v;
    v = 1'b0;
    if (sel >= clg_pkg::SRC_INT_BASE && sel <= clg_pkg::SRC_GATE_LAST) begin
      v = bits[sel - clg_pkg::SRC_INT_BASE];
    end
    return v;
  endfunction

  function automatic logic [7:0] obj_data(input logic [13:0] cfg, input logic [17:0] val,
                                          input logic bit_v);
    logic [7:0] d;
    if (cfg[clg_pkg::CFG_BYTE_BIT]) begin
      d = bit_v ? val[clg_pkg::VAL_B1_LSB +: 8] : val[clg_pkg::VAL_B0_LSB +: 8];
    end else begin
      d = {7'h00, (bit_v ? val[clg_pkg::VAL_CMD1_BIT] : val[clg_pkg::VAL_CMD0_BIT])
                  ^ cfg[clg_pkg::CFG_OINV_BIT]};
    end
    return d;
  endfunction

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [2:0]  gcnt_q;
  logic [13:0] cfg_q [NG];
  logic [15:0] src_q [NG];
  logic [17:0] val_q [NG];
  logic [31:0] dly_q [NG];
  logic [15:0] cyc_q [NG];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gcnt_q <= clg_pkg::GCNT_RST;
      for (int g = 0; g < NG; g++) begin
        cfg_q[g] <= clg_pkg::CFG_RST;
        src_q[g] <= 16'h0000;
        val_q[g] <= clg_pkg::VAL_RST;
        dly_q[g] <= 32'h0000_0000;
        cyc_q[g] <= 16'h0000;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == clg_pkg::REG_CTRL) begin
        gcnt_q <= (reg_wdata_in[clg_pkg::CTRL_GCNT_LSB +: 3] > clg_pkg::GCNT_RST) ?
                  clg_pkg::GCNT_RST : reg_wdata_in[clg_pkg::CTRL_GCNT_LSB +: 3];
      end
      for (int g = 0; g < NG; g++) begin
        if (reg_addr_in == clg_pkg::REG_CFG0 + 8'(4 * g)) cfg_q[g] <= reg_wdata_in[13:0];
        if (reg_addr_in == clg_pkg::REG_SRC0 + 8'(4 * g)) src_q[g] <= reg_wdata_in[15:0];
        if (reg_addr_in == clg_pkg::REG_VAL0 + 8'(4 * g)) val_q[g] <= reg_wdata_in[17:0];
        if (reg_addr_in == clg_pkg::REG_DLY0 + 8'(4 * g)) dly_q[g] <= reg_wdata_in;
        if (reg_addr_in == clg_pkg::REG_CYC0 + 8'(4 * g)) cyc_q[g] <= reg_wdata_in[15:0];
      end
    end
  end

  // ==========================================================================
  // Millisecond time base
  // ==========================================================================
  logic [15:0] pre_q;
  logic        tick_w;

  assign tick_w = (pre_q == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || tick_w) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Internal bit sources; previous copy detects new values
  // ==========================================================================
  logic [NG-1:0] gate_out_w;
  logic [NG-1:0] gate_raw_w;
  logic [NG-1:0] req_w;
  logic [NG-1:0] grant_w;
  logic [15:0]   held_w;
  logic [11:0]   bits_w;
  logic [11:0]   prev_q;

  assign bits_w = {gate_out_w, int_bits_in};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_q <= 12'h000;
    end else begin
      prev_q <= bits_w;
    end
  end

  // ==========================================================================
  // Gates
  // ==========================================================================
  for (genvar g = 0; g < NG; g++) begin : gen_gate
    logic [3:0]  in_q;
    logic        raw_q;
    logic        out_q;
    logic        tgt_q;
    logic        run_q;
    logic        req_q;
    logic [15:0] dcnt_q;
    logic [15:0] ccnt_q;
    logic [3:0]  arr_w;
    logic [3:0]  nv_w;
    logic [3:0]  mask_w;
    logic [3:0]  eff_w;
    logic [3:0]  comb_w;
    logic        res_w;
    logic        eval_w;
    logic        act_w;
    logic        fb_w;
    logic        apply_w;
    logic        app_val_w;
    logic        send_w;
    logic        cyc_fire_w;
    logic [1:0]  nin_w;
    logic [15:0] on_w;
    logic [15:0] off_w;
    clg_pkg::clg_op_t   op_w;
    clg_pkg::clg_send_t mode_w;

    assign act_w  = (3'(g) < gcnt_q);
    assign op_w   = clg_pkg::clg_op_t'(cfg_q[g][clg_pkg::CFG_OP_LSB +: 2]);
    assign mode_w = clg_pkg::clg_send_t'(cfg_q[g][clg_pkg::CFG_MODE_LSB +: 2]);
    assign nin_w  = cfg_q[g][clg_pkg::CFG_NIN_LSB +: 2];
    assign fb_w   = (op_w == clg_pkg::CLG_OP_AND_FB);
    assign on_w   = dly_q[g][15:0];
    assign off_w  = dly_q[g][31:16];
    assign mask_w = {nin_w == 2'h3, nin_w >= 2'h2, nin_w >= 2'h1, 1'b1};

    always_comb begin
      arr_w = 4'h0;
      nv_w  = 4'h0;
      for (int i = 0; i < NI; i++) begin
        if (src_q[g][4*i +: 4] == clg_pkg::SRC_EXT) begin
          arr_w[i] = obj_valid_in && (obj_gate_in == 2'(g)) && (obj_input_in == 2'(i));
          nv_w[i]  = obj_value_in;
        end else begin
          nv_w[i]  = src_val(src_q[g][4*i +: 4], bits_w);
          arr_w[i] = nv_w[i] != src_val(src_q[g][4*i +: 4], prev_q);
        end
      end
      arr_w  = arr_w & mask_w & {4{act_w}};
      eval_w = |arr_w;
      eff_w  = in_q;
      for (int i = 0; i < NI; i++) begin
        if (arr_w[i]) eff_w[i] = nv_w[i];
      end
      comb_w = eff_w ^ cfg_q[g][clg_pkg::CFG_INV_LSB +: 4];
      unique case (op_w)
        clg_pkg::CLG_OP_AND:    res_w = &(comb_w | ~mask_w);
        clg_pkg::CLG_OP_OR:     res_w = |(comb_w & mask_w);
        clg_pkg::CLG_OP_XOR:    res_w = ^(comb_w & mask_w);
        clg_pkg::CLG_OP_AND_FB: res_w = &(comb_w | ~mask_w);
      endcase
    end

    // Apply a result now when its delay is zero, or when the timer runs out
    always_comb begin
      apply_w   = 1'b0;
      app_val_w = res_w;
      if (eval_w) begin
        apply_w = res_w ? (on_w == 16'h0000) : (off_w == 16'h0000);
      end else if (run_q && tick_w && dcnt_q == 16'h0001) begin
        apply_w   = 1'b1;
        app_val_w = tgt_q;
      end
    end

    assign cyc_fire_w = act_w && cfg_q[g][clg_pkg::CFG_CYCEN_BIT] && cyc_q[g] != 16'h0000
                        && tick_w && ccnt_q <= 16'h0001;
    assign send_w = (apply_w && (mode_w == clg_pkg::CLG_SEND_EVENT ||
                    (mode_w == clg_pkg::CLG_SEND_CHANGE && app_val_w != out_q)))
                    || cyc_fire_w;

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        in_q  <= 4'h0;
        raw_q <= 1'b0;
      end else if (eval_w) begin
        in_q  <= eff_w;
        raw_q <= res_w;
        if (fb_w) in_q[0] <= res_w;
      end
    end

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        run_q  <= 1'b0;
        tgt_q  <= 1'b0;
        dcnt_q <= 16'h0000;
      end else if (eval_w) begin
        run_q  <= !apply_w;
        tgt_q  <= res_w;
        dcnt_q <= res_w ? on_w : off_w;
      end else if (run_q && tick_w) begin
        dcnt_q <= dcnt_q - 16'h0001;
        if (dcnt_q == 16'h0001) run_q <= 1'b0;
      end
    end

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        out_q <= 1'b0;
      end else if (apply_w) begin
        out_q <= app_val_w;
      end
    end

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        ccnt_q <= 16'h0000;
      end else if (!(act_w && cfg_q[g][clg_pkg::CFG_CYCEN_BIT])) begin
        ccnt_q <= cyc_q[g];
      end else if (tick_w) begin
        ccnt_q <= (ccnt_q <= 16'h0001) ? cyc_q[g] : ccnt_q - 16'h0001;
      end
    end

    // A new send request wins over the grant that clears the old one
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        req_q <= 1'b0;
      end else if (send_w) begin
        req_q <= 1'b1;
      end else if (grant_w[g]) begin
        req_q <= 1'b0;
      end
    end

    assign gate_out_w[g]    = out_q;
    assign gate_raw_w[g]    = raw_q;
    assign req_w[g]         = req_q;
    assign held_w[4*g +: 4] = in_q;
  end

  // ==========================================================================
  // Transmit arbiter, lowest gate first
  // ==========================================================================
  logic       busy_q;
  logic [1:0] pick_w;
  logic       any_w;

  always_comb begin
    pick_w = 2'h0;
    any_w  = 1'b0;
    for (int g = NG - 1; g >= 0; g--) begin
      if (req_w[g]) begin
        pick_w = 2'(g);
        any_w  = 1'b1;
      end
    end
    grant_w = '0;
    if (!busy_q && any_w) grant_w[pick_w] = 1'b1;
  end

  assign tx_valid_out = busy_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q      <= 1'b0;
      tx_gate_out <= 2'h0;
      tx_obj_out  <= 1'b0;
      tx_byte_out <= 1'b0;
      tx_data_out <= 8'h00;
    end else if (!busy_q) begin
      if (any_w) begin
        busy_q      <= 1'b1;
        tx_gate_out <= pick_w;
        tx_obj_out  <= 1'b0;
        tx_byte_out <= cfg_q[pick_w][clg_pkg::CFG_BYTE_BIT];
        tx_data_out <= obj_data(cfg_q[pick_w], val_q[pick_w], gate_out_w[pick_w]);
      end
    end else if (tx_ready_in) begin
      if (!tx_obj_out && cfg_q[tx_gate_out][clg_pkg::CFG_TWO_BIT]) begin
        tx_obj_out <= 1'b1;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register read, data one cycle after the strobe
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_addr_in == clg_pkg::REG_CTRL) reg_rdata_out <= {29'h0, gcnt_q};
      if (reg_addr_in == clg_pkg::REG_STATUS) begin
        reg_rdata_out <= {8'h00, held_w, gate_raw_w, gate_out_w};
      end
      for (int g = 0; g < NG; g++) begin
        if (reg_addr_in == clg_pkg::REG_CFG0 + 8'(4 * g)) reg_rdata_out <= {18'h0, cfg_q[g]};
        if (reg_addr_in == clg_pkg::REG_SRC0 + 8'(4 * g)) reg_rdata_out <= {16'h0, src_q[g]};
        if (reg_addr_in == clg_pkg::REG_VAL0 + 8'(4 * g)) reg_rdata_out <= {14'h0, val_q[g]};
        if (reg_addr_in == clg_pkg::REG_DLY0 + 8'(4 * g)) reg_rdata_out <= dly_q[g];
        if (reg_addr_in == clg_pkg::REG_CYC0 + 8'(4 * g)) reg_rdata_out <= {16'h0, cyc_q[g]};
      end
    end
  end

endmodule

// [tb/clg_gates_monitor.sv]
`timescale 1ns/1ps
module clg_gates_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic [1:0]  tx_gate_out,
  input wire logic        tx_obj_out,
  input wire logic        tx_byte_out,
  input wire logic [7:0]  tx_data_out
);
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Checks
  reset_idle_a: assert property ($fell(rst_in) |->
    (reg_rdata_out == 32'h0 && !tx_valid_out) ##1 !tx_valid_out) else $error("busy after reset");
  ctrl_range_a: assert property (reg_rd_in && reg_addr_in == clg_pkg::REG_CTRL |=>
    reg_rdata_out[31:3] == 29'h0 && reg_rdata_out[2:0] <= 3'h4) else $error("bad gate count");
  val_width_a: assert property (reg_rd_in && reg_addr_in == clg_pkg::REG_VAL0 |=>
    reg_rdata_out[31:18] == 14'h0) else $error("value word too wide");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
    $stable({tx_gate_out, tx_obj_out, tx_byte_out, tx_data_out})) else $error("tx not held");
  bit_data_a: assert property (tx_valid_out && !tx_byte_out |->
    tx_data_out[7:1] == 7'h00) else $error("bit object with upper bits");
  first_obj_a: assert property ($rose(tx_valid_out) |-> !tx_obj_out)
    else $error("burst not led by object 0");
  pair_same_a: assert property (tx_valid_out && tx_ready_in && !tx_obj_out |=>
    !tx_valid_out || (tx_obj_out && $stable({tx_gate_out, tx_byte_out, tx_data_out})))
    else $error("second object differs");
  gate_gap_a: assert property (tx_valid_out && tx_ready_in && tx_obj_out |=>
    !tx_valid_out) else $error("no gap after object 1");
endmodule

bind clg_gates clg_gates_monitor mon_u (
  .clk_in        (clk_in),
  .rst_in        (rst_in),
  .reg_addr_in   (reg_addr_in),
  .reg_rd_in     (reg_rd_in),
  .reg_rdata_out (reg_rdata_out),
  .tx_valid_out  (tx_valid_out),
  .tx_ready_in   (tx_ready_in),
  .tx_gate_out   (tx_gate_out),
  .tx_obj_out    (tx_obj_out),
  .tx_byte_out   (tx_byte_out),
  .tx_data_out   (tx_data_out)
);

// [tb/clg_bus_peer.sv]
`timescale 1ns/1ps
module clg_bus_peer (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic tx_valid_in,
  input  wire logic slow_in,
  output logic      tx_ready_out
);
  logic [1:0] wait_q;
  // ==========================================
  // Slow mode stalls each telegram three cycles
  always_ff @(posedge clk_in) begin
    if (rst_in || !tx_valid_in || tx_ready_out) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  assign tx_ready_out = tx_valid_in && (!slow_in || wait_q == 2'h3);
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        clk_in, rst_in, reg_wr_in, reg_rd_in, obj_valid_in, obj_value_in, slow, rd_q;
  logic [7:0]  reg_addr_in, int_bits_in, tx_data_out, b0, b1;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [1:0]  obj_gate_in, obj_input_in, tx_gate_out;
  logic        tx_valid_out, tx_ready_in, tx_obj_out, tx_byte_out;
  logic [31:0] rq[$];
  logic [11:0] tq[$];
  int          num_errors = 0;
  int          cmp_count = 0;

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  clg_gates #(.TICK_CYCLES(10)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .obj_valid_in(obj_valid_in),
    .obj_gate_in(obj_gate_in), .obj_input_in(obj_input_in), .obj_value_in(obj_value_in),
    .int_bits_in(int_bits_in), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .tx_gate_out(tx_gate_out), .tx_obj_out(tx_obj_out), .tx_byte_out(tx_byte_out),
    .tx_data_out(tx_data_out));
  clg_bus_peer peer_u (.clk_in(clk_in), .rst_in(rst_in), .tx_valid_in(tx_valid_out),
    .slow_in(slow), .tx_ready_out(tx_ready_in));

  // ==========================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_tx(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t telegram %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    rq.push_back(e);
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic send(input logic [1:0] g, input logic [1:0] i, input logic v);
    @(posedge clk_in);
    obj_valid_in <= 1'b1;
    obj_gate_in <= g;
    obj_input_in <= i;
    obj_value_in <= v;
    @(posedge clk_in);
    obj_valid_in <= 1'b0;
  endtask
  task automatic push2(input logic [1:0] g, input logic [7:0] d);
    tq.push_back({g, 1'b0, 1'b1, d});
    tq.push_back({g, 1'b1, 1'b1, d});
  endtask
  task automatic drain;
    for (int n = 0; n < 200 && tq.size() != 0; n++) @(posedge clk_in);
    chk(tq.size(), 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      chk({31'h0, tx_valid_out}, 32'h0);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================
  // Result watcher
  always @(posedge clk_in) rd_q <= reg_rd_in;
  always @(negedge clk_in) begin
    if (rd_q === 1'b1) chk(reg_rdata_out, rq.pop_front());
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
      chk_tx({tx_gate_out, tx_obj_out, tx_byte_out, tx_data_out},
             tq.size() != 0 ? tq.pop_front() : 12'hxxx);
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    test_done;
  end

  // ==========================================
  // Main sequence
  initial begin
    {rst_in, reg_wr_in, reg_rd_in, obj_valid_in, obj_value_in, slow} = 6'h20;
    {reg_addr_in, int_bits_in, obj_gate_in, obj_input_in, reg_wdata_in} = '0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(clg_pkg::REG_CTRL, 32'h4);
    rd(clg_pkg::REG_CFG0, 32'h0);
    rd(clg_pkg::REG_VAL0, 32'h20000);
    rd(clg_pkg::REG_STATUS, 32'h0);
    rd(8'hFC, 32'h0);
    $display("test reset done");
    tq.push_back({2'h0, 1'b0, 1'b0, 8'h01});
    send(2'h0, 2'h0, 1'b1);
    drain;
    wr(clg_pkg::REG_CFG0, 32'h400);
    tq.push_back({2'h0, 1'b0, 1'b0, 8'h00});
    send(2'h0, 2'h0, 1'b1);
    drain;
    $display("test and done");
    b0 = lfsr(8'h63);
    b1 = lfsr(b0);
    slow <= 1'b1;
    wr(clg_pkg::REG_VAL0 + 8'h04, {16'h0, b1, b0});
    wr(clg_pkg::REG_CFG0 + 8'h04, 32'h315);
    push2(2'h1, b0);
    send(2'h1, 2'h0, 1'b1);
    drain;
    push2(2'h1, b1);
    send(2'h1, 2'h1, 1'b1);
    drain;
    slow <= 1'b0;
    $display("test or done");
    wr(clg_pkg::REG_SRC0 + 8'h08, 32'h1);
    wr(clg_pkg::REG_CFG0 + 8'h08, 32'h802);
    tq.push_back({2'h2, 1'b0, 1'b0, 8'h01});
    int_bits_in <= 8'h01;
    drain;
    tq.push_back({2'h2, 1'b0, 1'b0, 8'h00});
    int_bits_in <= 8'h00;
    drain;
    $display("test xor done");
    wr(clg_pkg::REG_CFG0 + 8'h0C, 32'h807);
    send(2'h3, 2'h1, 1'b1);
    idle(6);
    tq.push_back({2'h3, 1'b0, 1'b0, 8'h01});
    send(2'h3, 2'h0, 1'b1);
    drain;
    tq.push_back({2'h3, 1'b0, 1'b0, 8'h00});
    send(2'h3, 2'h1, 1'b0);
    drain;
    send(2'h3, 2'h1, 1'b1);
    idle(6);
    $display("test feedback done");
    // Inputs here are sparse, never cyclic beside a running delay
    wr(clg_pkg::REG_CFG0, 32'h0);
    wr(clg_pkg::REG_DLY0, 32'h3);
    tq.push_back({2'h0, 1'b0, 1'b0, 8'h00});
    send(2'h0, 2'h0, 1'b0);
    drain;
    send(2'h0, 2'h0, 1'b1);
    repeat (15) @(posedge clk_in);
    send(2'h0, 2'h0, 1'b1);
    idle(19);
    tq.push_back({2'h0, 1'b0, 1'b0, 8'h01});
    drain;
    $display("test delay done");
    wr(clg_pkg::REG_CYC0 + 8'h04, 32'h2);
    push2(2'h1, b1);
    push2(2'h1, b1);
    wr(clg_pkg::REG_CFG0 + 8'h04, 32'h3315);
    drain;
    wr(clg_pkg::REG_CYC0 + 8'h04, 32'h0);
    wr(clg_pkg::REG_CFG0 + 8'h04, 32'h315);
    idle(45);
    $display("test cyclic done");
    wr(clg_pkg::REG_CTRL, 32'h1);
    int_bits_in <= 8'h01;
    repeat (3) @(posedge clk_in);
    int_bits_in <= 8'h00;
    idle(6);
    wr(clg_pkg::REG_CTRL, 32'h7);
    rd(clg_pkg::REG_CTRL, 32'h4);
    idle(4);
    $display("test count done");
    wr(clg_pkg::REG_SRC0 + 8'h08, 32'h9);
    wr(clg_pkg::REG_CFG0 + 8'h08, 32'h812);
    wr(clg_pkg::REG_DLY0, 32'h0003_0000);
    send(2'h0, 2'h0, 1'b0);
    repeat (15) @(posedge clk_in);
    send(2'h0, 2'h0, 1'b0);
    idle(19);
    tq.push_back({2'h0, 1'b0, 1'b0, 8'h00});
    tq.push_back({2'h2, 1'b0, 1'b0, 8'h01});
    drain;
    $display("test chain done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(clg_pkg::REG_STATUS, 32'h0);
    rd(clg_pkg::REG_SRC0 + 8'h08, 32'h0);
    $display("test reset again done");
    test_done;
  end
endmodule
